// [rtl/decode16_pkg.sv]
// Opcodes, register maps, immediate tables and operation codes of the 16-bit decoder.
package decode16_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions, major opcodes and minor opcodes.
  localparam int         OPC_LSB              = 10;
  localparam logic [5:0] MAJ_GROUP_A          = 6'h01;
  localparam logic [5:0] MAJ_GROUP_B          = 6'h09;
  localparam logic [5:0] MAJ_GROUP_C          = 6'h11;
  localparam logic [5:0] MAJ_GROUP_D          = 6'h13;
  localparam logic [5:0] MAJ_GROUP_E          = 6'h1b;
  localparam logic [5:0] MAJ_GROUP_F          = 6'h21;
  localparam logic [5:0] MAJ_COPY             = 6'h03;
  localparam logic [5:0] MAJ_AND_IMM          = 6'h2c;
  localparam logic [5:0] MAJ_LOAD_STACK       = 6'h12;
  localparam logic [5:0] MAJ_STORE_STACK      = 6'h32;
  localparam logic [5:0] MAJ_STORE_BYTE       = 6'h22;
  localparam logic [5:0] MAJ_STORE_HALF       = 6'h2a;
  localparam logic [5:0] MAJ_STORE_WORD       = 6'h3a;
  localparam logic [5:0] MAJ_BRANCH           = 6'h33;
  localparam logic [5:0] MAJ_BRANCH_EQZ       = 6'h23;
  localparam logic [5:0] MAJ_BRANCH_NEZ       = 6'h2b;
  localparam logic [4:0] MIN_JUMP_DELAYED     = 5'h0c;
  localparam logic [4:0] MIN_JUMP_COMPACT     = 5'h0d;
  localparam logic [4:0] MIN_JUMP_LINK        = 5'h0e;
  localparam logic [4:0] MIN_JUMP_LINK_SHORT  = 5'h0f;
  localparam logic [4:0] MIN_FROM_HIGH        = 5'h10;
  localparam logic [4:0] MIN_FROM_LOW         = 5'h12;
  localparam logic [4:0] MIN_JUMP_ADD_STACK   = 5'h18;
  localparam logic [5:0] MIN_BREAK            = 6'h28;
  localparam logic [5:0] MIN_DEBUG_BREAK      = 6'h2c;

  //////////////////////////////////////////////////////////////////////////////
  // Register numbers and three-bit specifier maps, code 0 in the low slot.
  localparam logic [4:0] REG_ZERO             = 5'h00;
  localparam logic [4:0] GLOBAL_POINTER       = 5'h1c;
  localparam logic [4:0] STACK_POINTER        = 5'h1d;
  localparam logic [4:0] RETURN_ADDRESS_REG   = 5'h1f;
  localparam logic [7:0][4:0] GEN_REG_MAP =
    {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h11, 5'h10};
  localparam logic [7:0][4:0] STORE_SRC_MAP =
    {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h11, 5'h00};
  localparam logic [7:0][4:0] PAIR_SRC_MAP =
    {5'h14, 5'h13, 5'h12, 5'h11, 5'h10, 5'h07, 5'h02, 5'h00};
  localparam logic [7:0][4:0] PAIR_DST_FIRST =
    {5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h06, 5'h05, 5'h05};
  localparam logic [7:0][4:0] PAIR_DST_SECOND =
    {5'h07, 5'h06, 5'h05, 5'h16, 5'h15, 5'h07, 5'h07, 5'h06};

  //////////////////////////////////////////////////////////////////////////////
  // Immediate tables and address steps.
  localparam logic [7:0][15:0] TWO_REG_IMM =
    {16'hffff, 16'h0018, 16'h0014, 16'h0010, 16'h000c, 16'h0008, 16'h0004, 16'h0001};
  localparam logic [15:0][15:0] AND_MASK =
    {16'hffff, 16'h8000, 16'h00ff, 16'h0080, 16'h0040, 16'h003f, 16'h0020, 16'h001f,
     16'h0010, 16'h000f, 16'h0008, 16'h0007, 16'h0004, 16'h0003, 16'h0002, 16'h0001};
  localparam logic [31:0] SHIFT_ZERO_AMOUNT   = 32'h0000_0008;
  localparam logic [31:0] ADJ_LOW_ADD         = 32'h0000_0100;
  localparam logic [31:0] ADJ_TOP_SUB         = 32'h0000_0300;
  localparam logic [31:0] ADJ_NEG_SUB         = 32'h0000_0200;
  localparam logic [31:0] HALF_STEP           = 32'h0000_0002;
  localparam logic [31:0] LINK_SLOT32         = 32'h0000_0006;
  localparam logic [31:0] LINK_SLOT16         = 32'h0000_0004;

  //////////////////////////////////////////////////////////////////////////////
  // Decoded operations.
  typedef enum logic [4:0] {
    long32, unknown16, copy_reg16, no_op16, add_unsigned16, sub_unsigned16, negate16,
    shift_left16, shift_right16, and_imm16, load_word_sp16, store_word_sp16,
    store_byte16, store_half16, store_word16, branch16, branch_eq_zero16,
    branch_ne_zero16, jump_reg_delayed, jump_reg_compact, jump_link_reg16,
    jump_link_reg_short16, jump_reg_add_sp16, move_from_high16, move_from_low16,
    item_a, debug_item_a, add_imm_two_reg16, add_imm_sp_to_reg16, adjust_sp16,
    add_imm_same_reg16, move_pair16
  } op_t;

  function automatic logic is_short_major(input logic [5:0] maj);
    case (maj)
      MAJ_GROUP_A, MAJ_GROUP_B, MAJ_GROUP_C, MAJ_GROUP_D, MAJ_GROUP_E, MAJ_GROUP_F,
      MAJ_COPY, MAJ_AND_IMM, MAJ_LOAD_STACK, MAJ_STORE_STACK, MAJ_STORE_BYTE,
      MAJ_STORE_HALF, MAJ_STORE_WORD, MAJ_BRANCH, MAJ_BRANCH_EQZ,
      MAJ_BRANCH_NEZ: is_short_major = 1'b1;
      default: is_short_major = 1'b0;
    endcase
  endfunction

endpackage

// [rtl/reg_spec_map.sv]
// Table lookup from a three-bit register specifier to a register number.
`timescale 1ns/100ps
module reg_spec_map #(
  parameter logic [7:0][4:0] MAP = '0
) (
  // Specifier in, register out.
  input  wire logic [2:0] code_i,
  output logic      [4:0] reg_o
);
  assign reg_o = MAP[code_i];
endmodule

// [rtl/compact16_decoder.sv]
// Decoder that splits fetch words into halfwords and expands 16-bit instructions.
`timescale 1ns/100ps
// Function
// - Register copy uses two full fields.
// - Stack load/store: stack base, offset times four.
// - Branch offset doubled, added to PC.
// - Copy zero to zero is no-op.
// - Negate is subtract from register zero.
// - General map: 0->16, 1->17, else same.
// - Store source map: 0->0, 1->17.
// - Implicit registers 29, 31.
// - Two-register add immediate table, general map.
// - AND immediate expands to sixteen masks.
// - Stack to register add, field times four.
// - Stack adjust decodes nine bits, times four.
// - Same register add, signed four bits.
// - Zero-compare branches, 7-bit offset doubled.
// - Compact register jump, no delay slot.
// - Breakpoints carry a four-bit code.
// - Pair move uses destination pair table.
// - Link address assumes 32 or 16-bit slot.
// - Five-bit fields reach all 32 registers.
// - Result moves copy high or low word.
// - Return and pop adds field times four.
// - Shift amount field decodes to 1..8.
// - Length comes from major opcode only.
// - First halfword chosen by endianness.
// - Add immediate codes 0..6, then -1.
module compact16_decoder
  import decode16_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Fetch side.
  input  wire logic [31:0] word_i,
  input  wire logic [31:0] word_addr_i,
  input  wire logic        word_valid_i,
  input  wire logic        big_endian_i,
  output logic             word_ready_o,
  // Decoded operation.
  output logic             dec_valid_o,
  output op_t              op_o,
  output logic             long_o,
  output logic      [31:0] raw_o,
  output logic      [31:0] pc_o,
  output logic      [4:0]  rs_o,
  output logic      [4:0]  rt_o,
  output logic      [4:0]  rd_o,
  output logic      [4:0]  rd2_o,
  output logic      [31:0] imm_o,
  output logic      [31:0] target_o,
  output logic      [31:0] link_o
);

  //////////////////////////////////////////////////////////////////////////////
  // State.
  typedef enum logic [1:0] {ST_EMPTY, ST_FIRST, ST_SECOND} fetch_state_t;

  typedef struct packed {
    fetch_state_t st;
    logic [31:0]  word;
    logic [31:0]  waddr;
    logic [15:0]  held;
    logic [31:0]  held_pc;
    logic         pend;
    logic         ready;
    logic         valid;
    op_t          op;
    logic         long;
    logic [31:0]  raw;
    logic [31:0]  pc;
    logic [4:0]   rs;
    logic [4:0]   rt;
    logic [4:0]   rd;
    logic [4:0]   rd2;
    logic [31:0]  imm;
    logic [31:0]  target;
    logic [31:0]  link;
  } dec_state_t;

  dec_state_t  dec_reg;
  dec_state_t  dec_next;
  logic [15:0] hw;
  logic [31:0] cur_pc;
  logic [31:0] adj_val;
  op_t         d_op;
  logic [4:0]  d_rs;
  logic [4:0]  d_rt;
  logic [4:0]  d_rd;
  logic [4:0]  d_rd2;
  logic [31:0] d_imm;
  logic [31:0] d_link;
  logic [4:0]  g97;
  logic [4:0]  g64;
  logic [4:0]  g31;
  logic [4:0]  s97;
  logic [4:0]  s31;
  logic [4:0]  p64;
  logic [4:0]  p31;

  //////////////////////////////////////////////////////////////////////////////
  // Three-bit specifier maps.
  // General, store source and pair source register maps.
  reg_spec_map #(.MAP(GEN_REG_MAP))   u_g97 (.code_i(hw[9:7]), .reg_o(g97));
  reg_spec_map #(.MAP(GEN_REG_MAP))   u_g64 (.code_i(hw[6:4]), .reg_o(g64));
  reg_spec_map #(.MAP(GEN_REG_MAP))   u_g31 (.code_i(hw[3:1]), .reg_o(g31));
  reg_spec_map #(.MAP(STORE_SRC_MAP)) u_s97 (.code_i(hw[9:7]), .reg_o(s97));
  reg_spec_map #(.MAP(STORE_SRC_MAP)) u_s31 (.code_i(hw[3:1]), .reg_o(s31));
  reg_spec_map #(.MAP(PAIR_SRC_MAP))  u_p64 (.code_i(hw[6:4]), .reg_o(p64));
  reg_spec_map #(.MAP(PAIR_SRC_MAP))  u_p31 (.code_i(hw[3:1]), .reg_o(p31));

  //////////////////////////////////////////////////////////////////////////////
  // Halfword selection, decode and sequencing.
  always_comb begin
    dec_next       = dec_reg;
    dec_next.valid = 1'b0;
    if ((dec_reg.st == ST_FIRST) ^ big_endian_i) begin
      hw = dec_reg.word[15:0];
    end else begin
      hw = dec_reg.word[31:16];
    end
    cur_pc = (dec_reg.st == ST_SECOND) ? dec_reg.waddr + HALF_STEP : dec_reg.waddr;
    adj_val = {23'h000000, hw[9:1]};
    if (hw[9:2] == 8'h00) begin
      adj_val = adj_val + ADJ_LOW_ADD;
    end else if (hw[9:2] == 8'hff) begin
      adj_val = adj_val - ADJ_TOP_SUB;
    end else if (hw[9]) begin
      adj_val = adj_val - ADJ_NEG_SUB;
    end
    d_op   = unknown16;
    d_rs   = REG_ZERO;
    d_rt   = REG_ZERO;
    d_rd   = REG_ZERO;
    d_rd2  = REG_ZERO;
    d_imm  = 32'h0000_0000;
    d_link = 32'h0000_0000;
    case (hw[15:OPC_LSB])
      MAJ_COPY: begin
        d_rd = hw[9:5];
        d_rs = hw[4:0];
        d_op = (hw[9:0] == 10'h000) ? no_op16 : copy_reg16;
      end
      MAJ_GROUP_A: begin
        d_rd = g97;
        d_rt = g64;
        if (hw[0]) begin
          d_rs = s31;
          d_op = (s31 == REG_ZERO) ? negate16 : sub_unsigned16;
        end else begin
          d_rs = g31;
          d_op = add_unsigned16;
        end
      end
      MAJ_GROUP_B: begin
        d_rd = g97;
        d_rs = g64;
        d_imm = (hw[3:1] == 3'h0) ? SHIFT_ZERO_AMOUNT : {29'h00000000, hw[3:1]};
        d_op  = hw[0] ? shift_right16 : shift_left16;
      end
      MAJ_GROUP_C: begin
        if (hw[9:4] == MIN_BREAK) begin
          d_op  = item_a;
          d_imm = {28'h0000000, hw[3:0]};
        end else if (hw[9:4] == MIN_DEBUG_BREAK) begin
          d_op  = debug_item_a;
          d_imm = {28'h0000000, hw[3:0]};
        end else begin
          case (hw[9:5])
            MIN_JUMP_DELAYED: begin
              d_op = jump_reg_delayed;
              d_rs = hw[4:0];
            end
            MIN_JUMP_COMPACT: begin
              d_op = jump_reg_compact;
              d_rs = hw[4:0];
            end
            MIN_JUMP_LINK: begin
              d_op   = jump_link_reg16;
              d_rs   = hw[4:0];
              d_rd   = RETURN_ADDRESS_REG;
              d_link = cur_pc + LINK_SLOT32;
            end
            MIN_JUMP_LINK_SHORT: begin
              d_op   = jump_link_reg_short16;
              d_rs   = hw[4:0];
              d_rd   = RETURN_ADDRESS_REG;
              d_link = cur_pc + LINK_SLOT16;
            end
            MIN_FROM_HIGH: begin
              d_op = move_from_high16;
              d_rd = hw[4:0];
            end
            MIN_FROM_LOW: begin
              d_op = move_from_low16;
              d_rd = hw[4:0];
            end
            MIN_JUMP_ADD_STACK: begin
              d_op  = jump_reg_add_sp16;
              d_rs  = RETURN_ADDRESS_REG;
              d_rt  = STACK_POINTER;
              d_rd  = STACK_POINTER;
              d_imm = {25'h0000000, hw[4:0], 2'h0};
            end
            default: d_op = unknown16;
          endcase
        end
      end
      MAJ_GROUP_D: begin
        if (hw[0]) begin
          d_op  = adjust_sp16;
          d_rs  = STACK_POINTER;
          d_rd  = STACK_POINTER;
          d_imm = {adj_val[29:0], 2'h0};
        end else begin
          d_op  = add_imm_same_reg16;
          d_rs  = hw[9:5];
          d_rd  = hw[9:5];
          d_imm = {{28{hw[4]}}, hw[4:1]};
        end
      end
      MAJ_GROUP_E: begin
        d_rd = g97;
        if (hw[0]) begin
          d_op  = add_imm_sp_to_reg16;
          d_rs  = STACK_POINTER;
          d_imm = {24'h000000, hw[6:1], 2'h0};
        end else begin
          d_op  = add_imm_two_reg16;
          d_rs  = g64;
          d_imm = {{16{TWO_REG_IMM[hw[3:1]][15]}}, TWO_REG_IMM[hw[3:1]]};
        end
      end
      MAJ_GROUP_F: begin
        if (!hw[0]) begin
          d_op  = move_pair16;
          d_rd  = PAIR_DST_FIRST[hw[9:7]];
          d_rd2 = PAIR_DST_SECOND[hw[9:7]];
          d_rs  = p64;
          d_rt  = p31;
        end
      end
      MAJ_AND_IMM: begin
        d_op  = and_imm16;
        d_rd  = g97;
        d_rs  = g64;
        d_imm = {16'h0000, AND_MASK[hw[3:0]]};
      end
      MAJ_LOAD_STACK, MAJ_STORE_STACK: begin
        d_rs  = STACK_POINTER;
        d_imm = {25'h0000000, hw[4:0], 2'h0};
        if (hw[15:OPC_LSB] == MAJ_LOAD_STACK) begin
          d_op = load_word_sp16;
          d_rd = hw[9:5];
        end else begin
          d_op = store_word_sp16;
          d_rt = hw[9:5];
        end
      end
      MAJ_STORE_BYTE, MAJ_STORE_HALF, MAJ_STORE_WORD: begin
        d_rt = s97;
        d_rs = g64;
        if (hw[15:OPC_LSB] == MAJ_STORE_BYTE) begin
          d_op  = store_byte16;
          d_imm = {28'h0000000, hw[3:0]};
        end else if (hw[15:OPC_LSB] == MAJ_STORE_HALF) begin
          d_op  = store_half16;
          d_imm = {27'h0000000, hw[3:0], 1'b0};
        end else begin
          d_op  = store_word16;
          d_imm = {26'h0000000, hw[3:0], 2'h0};
        end
      end
      MAJ_BRANCH: begin
        d_op  = branch16;
        d_imm = {{21{hw[9]}}, hw[9:0], 1'b0};
      end
      MAJ_BRANCH_EQZ, MAJ_BRANCH_NEZ: begin
        d_op  = (hw[15:OPC_LSB] == MAJ_BRANCH_EQZ) ? branch_eq_zero16 : branch_ne_zero16;
        d_rs  = g97;
        d_imm = {{24{hw[6]}}, hw[6:0], 1'b0};
      end
      default: d_op = unknown16;
    endcase
    case (dec_reg.st)
      ST_EMPTY: begin
        dec_next.ready = 1'b1;
        if (word_valid_i && dec_reg.ready) begin
          dec_next.word  = word_i;
          dec_next.waddr = word_addr_i;
          dec_next.ready = 1'b0;
          dec_next.st    = ST_FIRST;
        end
      end
      ST_FIRST, ST_SECOND: begin
        dec_next.st = (dec_reg.st == ST_FIRST) ? ST_SECOND : ST_EMPTY;
        if (dec_reg.pend) begin
          dec_next.pend   = 1'b0;
          dec_next.valid  = 1'b1;
          dec_next.op     = long32;
          dec_next.long   = 1'b1;
          dec_next.raw    = {dec_reg.held, hw};
          dec_next.pc     = dec_reg.held_pc;
          dec_next.rs     = REG_ZERO;
          dec_next.rt     = REG_ZERO;
          dec_next.rd     = REG_ZERO;
          dec_next.rd2    = REG_ZERO;
          dec_next.imm    = 32'h0000_0000;
          dec_next.target = 32'h0000_0000;
          dec_next.link   = 32'h0000_0000;
        end else if (is_short_major(hw[15:OPC_LSB])) begin
          dec_next.valid  = 1'b1;
          dec_next.op     = d_op;
          dec_next.long   = 1'b0;
          dec_next.raw    = {16'h0000, hw};
          dec_next.pc     = cur_pc;
          dec_next.rs     = d_rs;
          dec_next.rt     = d_rt;
          dec_next.rd     = d_rd;
          dec_next.rd2    = d_rd2;
          dec_next.imm    = d_imm;
          dec_next.target = cur_pc + d_imm;
          dec_next.link   = d_link;
        end else begin
          dec_next.held    = hw;
          dec_next.held_pc = cur_pc;
          dec_next.pend    = 1'b1;
        end
      end
      default: dec_next.st = ST_EMPTY;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  assign word_ready_o = dec_reg.ready;
  assign dec_valid_o  = dec_reg.valid;
  assign op_o         = dec_reg.op;
  assign long_o       = dec_reg.long;
  assign raw_o        = dec_reg.raw;
  assign pc_o         = dec_reg.pc;
  assign rs_o         = dec_reg.rs;
  assign rt_o         = dec_reg.rt;
  assign rd_o         = dec_reg.rd;
  assign rd2_o        = dec_reg.rd2;
  assign imm_o        = dec_reg.imm;
  assign target_o     = dec_reg.target;
  assign link_o       = dec_reg.link;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the fetch ready handshake and the decoded outputs.
  default clocking chk_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence word_taken;
    word_valid_i && word_ready_o;
  endsequence
  sequence ready_returns;
    !word_ready_o [*3] ##1 word_ready_o;
  endsequence

  chk_word_to_output: assert property (word_taken |-> ##[2:3] dec_valid_o)
    else $error("taken word produced no decoded output");
  chk_ready_cycle: assert property (word_taken |=> ready_returns)
    else $error("fetch ready did not return after three cycles");
  chk_copy_fields: assert property (dec_valid_o && op_o == copy_reg16 |->
    rd_o == raw_o[9:5] && rs_o == raw_o[4:0] && raw_o[9:0] != 10'h000)
    else $error("register copy fields wrong");
  chk_stack_offset: assert property (dec_valid_o &&
    (op_o == load_word_sp16 || op_o == store_word_sp16) |->
    rs_o == STACK_POINTER && imm_o == {25'h0000000, raw_o[4:0], 2'h0})
    else $error("stack-relative base or offset wrong");
  chk_branch_target: assert property (dec_valid_o && op_o == branch16 |->
    target_o == pc_o + {{21{raw_o[9]}}, raw_o[9:0], 1'b0})
    else $error("branch target wrong");
  chk_nop_alias: assert property (dec_valid_o && !long_o &&
    raw_o[15:0] == {MAJ_COPY, 10'h000} |-> op_o == no_op16)
    else $error("no-op alias not recognised");
  chk_negate_zero: assert property (dec_valid_o && op_o == negate16 |->
    rs_o == REG_ZERO && rt_o == GEN_REG_MAP[raw_o[6:4]])
    else $error("negate operands wrong");
  chk_general_map: assert property (dec_valid_o && op_o == and_imm16 |->
    rd_o == GEN_REG_MAP[raw_o[9:7]] && rs_o == GEN_REG_MAP[raw_o[6:4]])
    else $error("general specifier map wrong");
  chk_store_source: assert property (dec_valid_o && op_o == store_word16 |->
    rt_o == STORE_SRC_MAP[raw_o[9:7]] && imm_o == {26'h0000000, raw_o[3:0], 2'h0})
    else $error("store source or offset wrong");
  chk_two_reg_imm: assert property (dec_valid_o && op_o == add_imm_two_reg16 |->
    imm_o == {{16{TWO_REG_IMM[raw_o[3:1]][15]}}, TWO_REG_IMM[raw_o[3:1]]})
    else $error("two-register immediate wrong");
  chk_and_mask: assert property (dec_valid_o && op_o == and_imm16 |->
    imm_o == {16'h0000, AND_MASK[raw_o[3:0]]})
    else $error("AND mask wrong");
  chk_adjust_stack: assert property (dec_valid_o && op_o == adjust_sp16 |->
    rs_o == STACK_POINTER && rd_o == STACK_POINTER && imm_o[1:0] == 2'h0)
    else $error("stack adjust operands wrong");
  chk_same_reg_range: assert property (dec_valid_o && op_o == add_imm_same_reg16 |->
    rd_o == rs_o && $signed(imm_o) >= -8 && $signed(imm_o) <= 7)
    else $error("same-register add wrong");
  chk_link_slot: assert property (dec_valid_o && op_o == jump_link_reg16 |->
    link_o == pc_o + LINK_SLOT32 && rd_o == RETURN_ADDRESS_REG)
    else $error("link address for long slot wrong");
  chk_link_short: assert property (dec_valid_o && op_o == jump_link_reg_short16 |->
    link_o == pc_o + LINK_SLOT16)
    else $error("link address for short slot wrong");
  chk_pop_return: assert property (dec_valid_o && op_o == jump_reg_add_sp16 |->
    rs_o == RETURN_ADDRESS_REG && imm_o == {25'h0000000, raw_o[4:0], 2'h0})
    else $error("return and pop wrong");
  chk_shift_amount: assert property (dec_valid_o &&
    (op_o == shift_left16 || op_o == shift_right16) |-> imm_o != 0 && imm_o <= 8)
    else $error("shift amount out of range");

endmodule

// [dv/fetch_model.sv]
// Fetch-stage model that offers one word and holds it until it is taken.
`timescale 1ns/100ps
module fetch_model (
  // Bench control.
  input  wire logic        core_clk_i,
  input  wire logic        go_i,
  input  wire logic [31:0] word_i,
  input  wire logic [31:0] addr_i,
  // Decoder side.
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic             taken_o,
  output logic      [31:0] word_o,
  output logic      [31:0] addr_o
);
  initial {valid_o, taken_o, word_o, addr_o} = '0;
  always @(posedge core_clk_i) taken_o <= valid_o && ready_i;
  // A released word shows inverted data, never the last value.
  always @(negedge core_clk_i) begin
    if (taken_o) begin
      valid_o <= 1'b0;
      word_o  <= ~word_o;
    end else if (!valid_o && go_i) begin
      valid_o <= 1'b1;
      word_o  <= word_i;
      addr_o  <= addr_i;
    end
  end
endmodule

// [dv/compact16_decoder_tb.sv]
// Self-checking bench for the 16-bit instruction decoder.
`timescale 1ns/100ps
module compact16_decoder_tb
  import decode16_pkg::*;
;
  logic clk = 0, rst_n = 0, go = 0, be = 0, rdy, dv, lng, fv, tk;
  logic [31:0] w = 0, a = 0, fw, fa, raw, pc, imm, tg, lk;
  logic [4:0] rs, rt, rd, rd2;
  op_t op;
  logic [115:0] q[$];
  logic [37:0] q2[$];
  int bad_count = 0, cmp_count = 0;
  int tw[8] = '{1, 4, 8, 12, 16, 20, 24, -1};
  always #50 clk = ~clk;
  fetch_model fm (.core_clk_i(clk), .go_i(go), .word_i(w), .addr_i(a), .ready_i(rdy),
    .valid_o(fv), .taken_o(tk), .word_o(fw), .addr_o(fa));
  compact16_decoder dut (.core_clk_i(clk), .resetn_i(rst_n), .word_i(fw), .word_addr_i(fa),
    .word_valid_i(fv), .big_endian_i(be), .word_ready_o(rdy), .dec_valid_o(dv), .op_o(op),
    .long_o(lng), .raw_o(raw), .pc_o(pc), .rs_o(rs), .rt_o(rt), .rd_o(rd), .rd2_o(rd2),
    .imm_o(imm), .target_o(tg), .link_o(lk));
  always @(posedge clk) if (dv === 1'b1) q.push_back({op, rs, rt, rd, imm, tg, lk});
  always @(posedge clk) if (dv === 1'b1 && (op == long32 || op == move_pair16))
    q2.push_back({lng, raw, rd2});
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [115:0] ex(op_t o, logic [4:0] s, t, d, logic [31:0] i, p, l);
    return {o, s, t, d, i, p + i, l};
  endfunction
  task put(input logic [15:0] h0, h1, input logic [31:0] p, input logic e);
    int n;
    n = 0;
    @(negedge clk);
    be = e;
    w = e ? {h0, h1} : {h1, h0};
    a = p;
    go = 1;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tk !== 1'b1 && n < 50);
    @(negedge clk);
    go = 0;
    repeat (4) @(negedge clk);
  endtask
  task pop(input logic [115:0] e);
    cmp_count++;
    if (q.size() == 0 || q[0] !== e) begin
      bad_count++;
      $display("mismatch decode exp %h got %h", e, q.size() ? q[0] : 'x);
    end
    if (q.size()) void'(q.pop_front());
  endtask
  task pop_side(input logic [37:0] e);
    cmp_count++;
    if (q2.size() == 0 || q2[0] !== e) begin
      bad_count++;
      $display("mismatch length_raw_pair exp %h got %h", e, q2.size() ? q2[0] : 'x);
    end
    if (q2.size()) void'(q2.pop_front());
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_copy(input logic e);
    put({6'h03, 5'd31, 5'd5}, 16'h0c00, 32'h100, e);
    pop(ex(copy_reg16, 5, 0, 31, 0, 32'h100, 0));
    pop(ex(no_op16, 0, 0, 0, 0, 32'h102, 0));
  endtask
  task t_alu;
    put({6'h01, 3'd0, 3'd1, 3'd0, 1'b1}, {6'h01, 3'd2, 3'd3, 3'd0, 1'b0}, 32'h200, 0);
    pop(ex(negate16, 0, 17, 16, 0, 32'h200, 0));
    pop(ex(add_unsigned16, 16, 3, 2, 0, 32'h202, 0));
  endtask
  task t_imm;
    for (int i = 0; i < 4; i++) begin
      put({6'h1b, 3'd2, 3'd3, 3'(2 * i), 1'b0}, {6'h1b, 3'd2, 3'd3, 3'(2 * i + 1), 1'b0},
        32'h500 + 8 * i, 0);
      pop(ex(add_imm_two_reg16, 3, 0, 2, tw[2 * i], 32'h500 + 8 * i, 0));
      pop(ex(add_imm_two_reg16, 3, 0, 2, tw[2 * i + 1], 32'h502 + 8 * i, 0));
    end
  endtask
  task t_flow;
    put({6'h33, 10'h3ff}, {6'h23, 3'd0, 7'h40}, 32'h300, 0);
    pop(ex(branch16, 0, 0, 0, 32'hfffffffe, 32'h300, 0));
    pop(ex(branch_eq_zero16, 16, 0, 0, 32'hffffff80, 32'h302, 0));
    put({6'h11, 5'h0e, 5'd9}, {6'h11, 5'h0f, 5'd9}, 32'h400, 0);
    pop(ex(jump_link_reg16, 9, 0, 31, 0, 32'h400, 32'h406));
    pop(ex(jump_link_reg_short16, 9, 0, 31, 0, 32'h402, 32'h406));
    put({6'h13, 9'h1fe, 1'b1}, {6'h11, 5'h18, 5'd3}, 32'h600, 0);
    pop(ex(adjust_sp16, 29, 0, 29, 32'hfffffbf8, 32'h600, 0));
    pop(ex(jump_reg_add_sp16, 31, 29, 29, 12, 32'h602, 0));
  endtask
  task t_misc;
    put({6'h00, 10'h021}, 16'h3840, 32'h700, 0);
    pop(ex(long32, 0, 0, 0, 0, 32'h0, 0));
    pop_side({1'b1, 32'h0021_3840, 5'd0});
    put({6'h21, 3'd3, 3'd1, 3'd2, 1'b0}, {6'h21, 3'd7, 3'd0, 3'd0, 1'b1}, 32'h710, 1);
    pop(ex(move_pair16, 2, 7, 4, 0, 32'h710, 0));
    pop_side({1'b0, 16'h0000, 6'h21, 3'd3, 3'd1, 3'd2, 1'b0, 5'd21});
    pop(ex(unknown16, 0, 0, 0, 0, 32'h712, 0));
    put({6'h3a, 3'd0, 3'd2, 4'h3}, {6'h2c, 3'd1, 3'd0, 4'he}, 32'h720, 0);
    pop(ex(store_word16, 2, 0, 0, 12, 32'h720, 0));
    pop(ex(and_imm16, 16, 0, 17, 32'h8000, 32'h722, 0));
    put({6'h09, 3'd2, 3'd3, 3'd0, 1'b1}, {6'h13, 5'd30, 4'h8, 1'b0}, 32'h730, 0);
    pop(ex(shift_right16, 3, 0, 2, 8, 32'h730, 0));
    pop(ex(add_imm_same_reg16, 30, 0, 30, 32'hfffffff8, 32'h732, 0));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    t_copy(0);
    t_copy(1);
    t_alu;
    t_imm;
    t_flow;
    t_misc;
    give_verdict;
  end
  initial begin
    #(3000 * 100);
    bad_count++;
    give_verdict;
  end
endmodule
